// ---- pkg/bcac_pkg.sv ----
/*
 * Constants for the bus controller area configuration block.
 * Assumes a plain register port on mclk, read data one cycle after the strobe.
 */
package bcac_pkg;
    // ------------------------------------------------------------------
    // Register offsets (register index on the plain port)
    // ------------------------------------------------------------------
    localparam logic [3:0]  ARB_CTRL_OFS     = 4'h0;
    localparam logic [3:0]  ENDIAN_SEL_OFS   = 4'h1;
    localparam logic [3:0]  SRAM_SEL_OFS     = 4'h2;
    localparam logic [3:0]  ARB_STATE_OFS    = 4'h3;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int          ARB_ALT_BIT      = 4;
    localparam int          PWB_EN_BIT       = 0;
    localparam int          ARB_ONE_BIT      = 1;
    localparam logic [7:0]  ARB_CTRL_RST     = 8'h02;
    localparam logic [7:0]  ARB_CTRL_WMASK   = 8'h11;
    localparam logic [7:0]  ENDIAN_WMASK     = 8'hfc;
    localparam logic [7:0]  ENDIAN_RST       = 8'h00;
    localparam logic [15:0] SRAM_WMASK       = 16'hff00;
    localparam logic [15:0] SRAM_RST         = 16'h0000;
    localparam int          SRAM_SEL_LSB     = 8;

    // Bus master owner encoding
    typedef enum logic [1:0]
    {
        OWN_IDLE = 2'b00,
        OWN_CPU  = 2'b01,
        OWN_DTC  = 2'b10
    } bcac_owner_t;
endpackage

// ---- src/bcac_top.sv ----
/*
 * Area configuration registers, internal arbiter and external byte lane
 * steering of the bus controller.
 * Holds three registers: arbitration and write buffer control, the
 * per-area endian select for areas 7 to 2 and the per-area byte-strobe
 * SRAM interface select for areas 7 to 0. Around them sit the internal
 * arbiter between the processor core and the data transfer controller,
 * the peripheral write buffer enable and the lane steering of external
 * accesses.
 * Assumes requesters hold their request until granted and one access per cycle.
 * Assumes the register port, both requesters and the external access logic
 * run on mclk, so no input needs a synchroniser.
 * Assumes area_width_cfg mirrors the area width register kept elsewhere:
 * bit n high marks area n as 16-bit access space, low as 8-bit.
 * Assumes ext_size codes 0 for a byte, 1 for a word and 2 for a long word,
 * and that the burst ROM and multiplexed bus selects of an area are cleared
 * by software before its SRAM select is set.
 */
module bcac_top
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // Arbiter requests and grants
    input  wire logic        cpu_req,
    input  wire logic        dtc_req,
    output logic             cpu_gnt,
    output logic             dtc_gnt,
    // Peripheral write buffer control
    output logic             periph_wbuf_en,
    // External access description
    input  wire logic [2:0]  ext_area,
    input  wire logic [7:0]  area_width_cfg,
    input  wire logic [1:0]  ext_size,
    input  wire logic [31:0] int_wdata,
    input  wire logic [31:0] ext_rdata,
    // External access results
    output logic             ext_sram_if,
    output logic             ext_little,
    output logic      [31:0] ext_wdata,
    output logic      [31:0] int_rdata
);
    // ------------------------------------------------------------------
    // Access size codes on ext_size; a byte access is never reordered
    // ------------------------------------------------------------------
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_LONG = 2'h2;

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [7:0]  arb_ctrl_ff;
    logic [7:0]  nxt_arb_ctrl;
    logic [7:0]  endian_ff;
    logic [7:0]  nxt_endian;
    logic [15:0] sram_ff;
    logic [15:0] nxt_sram;
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;

    // Arbiter owner, kept here because the owner status register reads it
    bcac_pkg::bcac_owner_t owner_ff;
    bcac_pkg::bcac_owner_t nxt_owner;

    // Named fields of the arbitration and write buffer control register
    logic        arbiter_alternate_mode;
    logic        peripheral_write_buffer_en;

    // Register map on reg_addr:
    //   index 0  arbitration and write buffer control, 8 bits wide
    //            bit 4 alternate arbitration, bit 1 always reads one,
    //            bit 0 peripheral write buffer enable, others read zero
    //   index 1  area endian select, bits 7 to 2 for areas 7 to 2
    //   index 2  area SRAM interface select, bits 15 to 8 for areas 7 to 0,
    //            bits 7 to 0 read zero
    //   index 3  arbiter owner status, bits 1 and 0, read only
    //            1 for the processor core, 2 for the transfer controller
    // Other indices read zero and ignore writes.

    // Next register values; only writable bits take data. Bit 1 of the
    // control register is forced high and bit 5 is never stored, so a
    // careless write cannot disturb either of them. Reserved bits of all
    // three registers drop out through their write masks.
    always_comb
    begin
        nxt_arb_ctrl = arb_ctrl_ff;
        nxt_endian   = endian_ff;
        nxt_sram     = sram_ff;
        if (reg_wr && reg_addr == bcac_pkg::ARB_CTRL_OFS)
        begin
            nxt_arb_ctrl = (reg_wdata[7:0] & bcac_pkg::ARB_CTRL_WMASK)
                         | bcac_pkg::ARB_CTRL_RST;
        end
        else if (reg_wr && reg_addr == bcac_pkg::ENDIAN_SEL_OFS)
        begin
            nxt_endian = reg_wdata[7:0] & bcac_pkg::ENDIAN_WMASK;
        end
        else if (reg_wr && reg_addr == bcac_pkg::SRAM_SEL_OFS)
        begin
            nxt_sram = reg_wdata & bcac_pkg::SRAM_WMASK;
        end
    end

    // Read data, one cycle after the strobe; unmapped reads return zero.
    // Outside a read the bus shows zero, so a stale value never lingers
    // where a master could mistake it for a fresh answer.
    always_comb
    begin
        nxt_rdata = 16'h0000;
        if (reg_rd && reg_addr == bcac_pkg::ARB_CTRL_OFS)
        begin
            nxt_rdata = {8'h00, arb_ctrl_ff};
        end
        else if (reg_rd && reg_addr == bcac_pkg::ENDIAN_SEL_OFS)
        begin
            nxt_rdata = {8'h00, endian_ff};
        end
        else if (reg_rd && reg_addr == bcac_pkg::SRAM_SEL_OFS)
        begin
            nxt_rdata = sram_ff;
        end
        else if (reg_rd && reg_addr == bcac_pkg::ARB_STATE_OFS)
        begin
            nxt_rdata = {14'h0000, owner_ff};
        end
    end

    // Register update. Reset loads the power-on values, with bit 1 of the
    // control register already high.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            arb_ctrl_ff <= bcac_pkg::ARB_CTRL_RST;
            endian_ff   <= bcac_pkg::ENDIAN_RST;
            sram_ff     <= bcac_pkg::SRAM_RST;
            rdata_ff    <= 16'h0000;
        end
        else
        begin
            arb_ctrl_ff <= nxt_arb_ctrl;
            endian_ff   <= nxt_endian;
            sram_ff     <= nxt_sram;
            rdata_ff    <= nxt_rdata;
        end
    end

    // Field aliases and register outputs
    assign arbiter_alternate_mode     = arb_ctrl_ff[bcac_pkg::ARB_ALT_BIT];
    assign peripheral_write_buffer_en = arb_ctrl_ff[bcac_pkg::PWB_EN_BIT];
    assign reg_rdata                  = rdata_ff;
    assign periph_wbuf_en             = peripheral_write_buffer_en;

    // ------------------------------------------------------------------
    // Internal bus arbiter
    // ------------------------------------------------------------------
    // Owner of the last grant, lone or contested; in alternate mode the other
    // requester wins the next conflict. Reset leaves it at the processor, so the first
    // conflict before any transfer controller grant goes to the transfer controller.
    logic                  last_dtc_ff;
    logic                  nxt_last_dtc;

    // Grant for next cycle: the transfer controller has fixed priority,
    // alternate mode swaps owners when both request. A lone request is
    // always granted at once, whatever the mode. The owner stands one
    // cycle and is worked out again at every edge, so a dropped request
    // frees the bus on the next edge.
    always_comb
    begin
        nxt_owner    = bcac_pkg::OWN_IDLE;
        nxt_last_dtc = last_dtc_ff;
        // A conflict is settled by the mode bit
        if (cpu_req && dtc_req)
        begin
            if (arbiter_alternate_mode)
            begin
                nxt_owner = last_dtc_ff ? bcac_pkg::OWN_CPU : bcac_pkg::OWN_DTC;
            end
            else
            begin
                nxt_owner = bcac_pkg::OWN_DTC;
            end
        end
        else if (dtc_req)
        begin
            nxt_owner = bcac_pkg::OWN_DTC;
        end
        else if (cpu_req)
        begin
            nxt_owner = bcac_pkg::OWN_CPU;
        end
        // Remember the winner for the next conflict
        if (nxt_owner == bcac_pkg::OWN_DTC)
        begin
            nxt_last_dtc = 1'b1;
        end
        else if (nxt_owner == bcac_pkg::OWN_CPU)
        begin
            nxt_last_dtc = 1'b0;
        end
    end

    // Arbiter state. Reset leaves the bus idle with no grant, so nothing
    // owns the bus until a request has been sampled.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            owner_ff    <= bcac_pkg::OWN_IDLE;
            last_dtc_ff <= 1'b0;
        end
        else
        begin
            owner_ff    <= nxt_owner;
            last_dtc_ff <= nxt_last_dtc;
        end
    end

    // Grants decoded from the owner register, so they never glitch
    assign cpu_gnt = (owner_ff == bcac_pkg::OWN_CPU);
    assign dtc_gnt = (owner_ff == bcac_pkg::OWN_DTC);

    // ------------------------------------------------------------------
    // External access steering
    // ------------------------------------------------------------------
    logic        sram_if_ff;
    logic        nxt_sram_if;
    logic        little_ff;
    logic        nxt_little;
    logic [31:0] ext_wdata_ff;
    logic [31:0] nxt_ext_wdata;
    logic [31:0] int_rdata_ff;
    logic [31:0] nxt_int_rdata;
    logic [7:0]  area_sram_sel;
    logic [7:0]  area_swap_sel;

    // Per-area decode of the interface and endian selects. An area marked
    // as 8-bit access space never takes the byte-strobe SRAM interface,
    // whatever its select bit says. Areas 0 and 1 have no endian select
    // and always stay big endian.
    for (genvar n = 0; n < 8; n++)
    begin : g_area
        assign area_sram_sel[n] = sram_ff[bcac_pkg::SRAM_SEL_LSB + n]
                                & area_width_cfg[n];
        if (n >= 2)
        begin : g_swap
            assign area_swap_sel[n] = endian_ff[n];
        end
        else
        begin : g_fixed
            assign area_swap_sel[n] = 1'b0;
        end
    end

    // Byte lane reversal for little endian areas. Internal data stays big
    // endian; only the lanes toward the external bus are reordered, and a
    // byte access needs no reordering. A little endian word access carries
    // the low two lanes only, so its upper half is cleared.
    always_comb
    begin
        nxt_sram_if   = area_sram_sel[ext_area];
        nxt_little    = area_swap_sel[ext_area];
        nxt_ext_wdata = int_wdata;
        nxt_int_rdata = ext_rdata;
        if (nxt_little && ext_size == SIZE_WORD)
        begin
            nxt_ext_wdata = {16'h0000, int_wdata[7:0], int_wdata[15:8]};
            nxt_int_rdata = {16'h0000, ext_rdata[7:0], ext_rdata[15:8]};
        end
        else if (nxt_little && ext_size == SIZE_LONG)
        begin
            nxt_ext_wdata = {int_wdata[7:0], int_wdata[15:8],
                             int_wdata[23:16], int_wdata[31:24]};
            nxt_int_rdata = {ext_rdata[7:0], ext_rdata[15:8],
                             ext_rdata[23:16], ext_rdata[31:24]};
        end
    end

    // Steering outputs registered; they follow the access inputs by one
    // cycle and are recomputed at every edge, so nothing is held over
    // from an earlier access.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sram_if_ff   <= 1'b0;
            little_ff    <= 1'b0;
            ext_wdata_ff <= 32'h0000_0000;
            int_rdata_ff <= 32'h0000_0000;
        end
        else
        begin
            sram_if_ff   <= nxt_sram_if;
            little_ff    <= nxt_little;
            ext_wdata_ff <= nxt_ext_wdata;
            int_rdata_ff <= nxt_int_rdata;
        end
    end

    assign ext_sram_if = sram_if_ff;
    assign ext_little  = little_ff;
    assign ext_wdata   = ext_wdata_ff;
    assign int_rdata   = int_rdata_ff;
endmodule

// ---- testbench/bcac_top_asserts.sv ----
/* Port checker for bcac_top.
   Bound from the bench top file; sees only top ports. */
module bcac_top_asserts
(
    // Clock, reset, register port
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic [3:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    // Arbiter and external side
    input wire logic        cpu_req,
    input wire logic        dtc_req,
    input wire logic        cpu_gnt,
    input wire logic        dtc_gnt,
    input wire logic        periph_wbuf_en,
    input wire logic [2:0]  ext_area,
    input wire logic [7:0]  area_width_cfg,
    input wire logic        ext_sram_if,
    input wire logic        ext_little
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic alt_ff;
    logic nxt_alt;
    wire  ctl_wr = reg_wr && reg_addr == bcac_pkg::ARB_CTRL_OFS;
    wire  ctl_rd = reg_rd && reg_addr == bcac_pkg::ARB_CTRL_OFS;
    wire  wb_bit = reg_wdata[bcac_pkg::PWB_EN_BIT];
    // Shadow of the arbiter mode bit
    always_comb nxt_alt = ctl_wr ? reg_wdata[bcac_pkg::ARB_ALT_BIT] : alt_ff;
    always_ff @(posedge mclk or negedge rst_n)
        if (!rst_n) alt_ff <= 1'b0;
        else alt_ff <= nxt_alt;
    // Two cycles of conflict in alternate mode
    sequence s_alt2;
        alt_ff && cpu_req && dtc_req ##1 alt_ff && cpu_req && dtc_req;
    endsequence
    a_wbuf_follows: assert property (ctl_wr |=> periph_wbuf_en == $past(wb_bit))
        else $error("write buffer enable wrong");
    a_ctrl_one: assert property (ctl_rd |=> reg_rdata[1])
        else $error("control bit 1 not one");
    a_ctrl_zero: assert property (ctl_rd |=> !reg_rdata[5])
        else $error("control bit 5 not zero");
    a_resv_zero: assert property (ctl_rd |=> reg_rdata[15:6] == 0 && reg_rdata[3:2] == 0)
        else $error("reserved bits not zero");
    a_fixed_prio: assert property (!alt_ff && cpu_req && dtc_req |=> dtc_gnt && !cpu_gnt)
        else $error("fixed priority broken");
    a_alt_swap: assert property (s_alt2 |=> dtc_gnt != $past(dtc_gnt) && cpu_gnt != dtc_gnt)
        else $error("grants do not alternate");
    a_sram_8bit: assert property (!area_width_cfg[ext_area] |=> !ext_sram_if)
        else $error("sram interface on 8-bit area");
    a_low_big: assert property (ext_area < 3'd2 |=> !ext_little)
        else $error("area 0 or 1 not big endian");
endmodule

// ---- testbench/bcac_ext_mem.sv ----
/* External memory stand-in driving the read lanes.
   Shows a new word every cycle, never a held value. */
module bcac_ext_mem
(
    // Clock and reset
    input wire logic    mclk,
    input wire logic    rst_n,
    // Read lanes toward the block
    output logic [31:0] ext_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] nxt_data;
    // Feedback shift pattern
    always_comb nxt_data = {ext_rdata[30:0], ext_rdata[31] ^ ext_rdata[21] ^ ext_rdata[1]};
    always_ff @(posedge mclk or negedge rst_n)
        if (!rst_n) ext_rdata <= 32'h1234_5678;
        else ext_rdata <= nxt_data;
endmodule

// ---- testbench/bcac_top_tb.sv ----
/* Self-checking bench for bcac_top with integer register model.
   Assumes bcac_pkg and the memory stand-in are compiled first. */
module bcac_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, cpu_req = 0, dtc_req = 0;
    logic [3:0]  reg_addr = 0;
    logic [15:0] reg_wdata = 0, reg_rdata;
    logic [7:0]  area_width_cfg = 0;
    logic [2:0]  ext_area = 0;
    logic [1:0]  ext_size = 0;
    logic [31:0] int_wdata = 0, ext_rdata, ext_wdata, int_rdata, cap, mk;
    logic        cpu_gnt, dtc_gnt, periph_wbuf_en, ext_sram_if, ext_little, e, ld = 0;
    int          error_cnt = 0, checks_done = 0, seed = 94860, m[16], k, lt;
    int          wm[3] = '{bcac_pkg::ARB_CTRL_WMASK, bcac_pkg::ENDIAN_WMASK, bcac_pkg::SRAM_WMASK};
    bcac_top i_dut(.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .cpu_req, .dtc_req, .cpu_gnt, .dtc_gnt, .periph_wbuf_en, .ext_area, .area_width_cfg,
        .ext_size, .int_wdata, .ext_rdata, .ext_sram_if, .ext_little, .ext_wdata, .int_rdata);
    bcac_ext_mem i_mem(.mclk, .rst_n, .ext_rdata);
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        checks_done++;
        if (s !== e)
        begin
            error_cnt++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask
    // One register access; a read is compared with the model
    task automatic acc(logic w, logic [3:0] a, logic [15:0] d);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        if (w && a < 3)
            m[a] = (d & wm[a]) | (a == 0 ? 2 : 0);
        @(posedge mclk);
        reg_wr <= 0;
        reg_rd <= 0;
        #1;
        if (!w)
            chk("rdata", {16'h0000, reg_rdata}, m[a]);
        @(posedge mclk);
    endtask
    // Byte lane order expected on a little-endian area
    function automatic logic [31:0] sw(logic [31:0] v, logic [1:0] s, int l);
        if (!l || s == 0)
            return v;
        if (s == 1)
            return {v[31:16], v[7:0], v[15:8]};
        return {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial forever #12.5 mclk = ~mclk;
    // Hang guard
    initial
    begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        report_and_stop;
    end
    initial
    begin
        m[0] = bcac_pkg::ARB_CTRL_RST;
        repeat (3) @(posedge mclk);
        rst_n <= 1;
        @(posedge mclk);
        for (k = 0; k < 6; k++)
            acc(0, k[3:0], 0);
        repeat (20)
        begin
            k = {$random(seed)} % 6;
            acc(1, k[3:0], 16'($random(seed)));
            acc(0, k[3:0], 0);
            chk("wbuf", periph_wbuf_en, m[0] & 1);
        end
        $display("test regs done");
        for (lt = 0; lt < 2; lt++)
        begin
            acc(1, 0, lt ? 16'h0012 : 16'h0002);
            cpu_req <= 1;
            dtc_req <= 1;
            repeat (6)
            begin
                @(posedge mclk);
                #1;
                e = lt ? !ld : 1'b1;
                chk("gnt", {cpu_gnt, dtc_gnt}, {!e, e});
                ld = e;
            end
            // Owner status while both still request; two more grants pass
            m[3] = e ? 2 : 1;
            acc(0, 3, 0);
            m[3] = 0;
            cpu_req <= 0;
            dtc_req <= 0;
        end
        $display("test arbiter done");
        @(posedge mclk);
        // Area 2 holds code and stack, so it stays big endian
        acc(1, 1, 16'($random(seed)) & 16'hfffb);
        acc(1, 2, 16'($random(seed)));
        repeat (40)
        begin
            ext_area <= 3'($random(seed));
            ext_size <= 2'({$random(seed)} % 3);
            area_width_cfg <= 8'($random(seed));
            int_wdata <= $random(seed);
            #1 cap = ext_rdata;
            @(posedge mclk);
            #1;
            lt = ext_area >= 2 && m[1][ext_area];
            mk = (lt && ext_size == 1) ? 32'h0000_ffff : 32'hffff_ffff;
            chk("little", ext_little, lt);
            chk("sram", ext_sram_if, m[2][8 + ext_area] && area_width_cfg[ext_area]);
            chk("wdata", ext_wdata & mk, sw(int_wdata, ext_size, lt) & mk);
            chk("irdata", int_rdata & mk, sw(cap, ext_size, lt) & mk);
            @(posedge mclk);
        end
        $display("test ext done");
        report_and_stop;
    end
endmodule
bind bcac_top bcac_top_asserts i_chk(.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .cpu_req, .dtc_req, .cpu_gnt, .dtc_gnt, .periph_wbuf_en, .ext_area,
    .area_width_cfg, .ext_sram_if, .ext_little);
